// [design/sps_pkg.sv]
// Package: constants and types of the stepper phase sequencer
`default_nettype none
package sps_pkg;
  // Clock rate and input hold figures
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned RESET_WAIT_NS   = 10_000;
  localparam int unsigned RESET_WAIT_CYC  = (RESET_WAIT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned SYNC_STAGES     = 3;

  // Phase index after reset: state 0 of the eight-step wheel drives A and B-neg
  localparam logic [2:0] PHASE_INIT = 3'h0;

  // Winding drive bundle
  typedef struct packed {
    logic one_pos;
    logic two_pos;
    logic one_neg;
    logic two_neg;
  } sps_drive_s;

  localparam sps_drive_s DRIVE_OFF = '{default: 1'b0};

  // Control inputs after synchronisation
  typedef struct packed {
    logic excitation_select;
    logic edge_select;
    logic direction_select;
    logic enable;
    logic step_clock;
  } sps_ctrl_s;
endpackage
`default_nettype wire

// [design/sps_sync.sv]
// Three-stage input synchroniser with agreement filter
`default_nettype none
module sps_sync
  import sps_pkg::*;
#(
  parameter int unsigned WIDTH = 5
) (
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] async_in,
  input  wire logic [WIDTH-1:0] init_val,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  always_ff @(posedge clk_sys) begin
    s1_reg <= async_in;
    s2_reg <= s1_reg;
    s3_reg <= s2_reg;
  end

  // A change counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          sync_out[gi] <= init_val[gi];
        end else if (s2_reg[gi] == s3_reg[gi]) begin
          sync_out[gi] <= s3_reg[gi];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// [design/sps_sequencer.sv]
// Top: phase sequencer of a unipolar two-phase stepping motor driver
// Functional notes
// - Edge select high: advance one step on each rising step clock edge only.
// - Excitation select low gives full-step, high gives half-step excitation.
// - Edge select low: rising and falling step clock edges both advance.
// - Direction select low steps forward, high steps reverse.
// - Sequencer held in reset while system_reset_n is low.
// - After reset release start with winding one positive and two negative on.
// - Enable low forces all four winding outputs off.
// - Enable high again resumes from the sequence position, which steps taken while enable was low still advance.
// - Fault output low whenever overcurrent or overheat was detected; a detection during power-on or pin reset is not flagged.
// - Detected fault latches outputs off until power-on or pin reset.
`default_nettype none
module sps_sequencer
  import sps_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic step_clock,
  input  wire logic excitation_select,
  input  wire logic edge_select,
  input  wire logic direction_select,
  input  wire logic system_reset_n,
  input  wire logic enable,
  input  wire logic overcurrent_detect,
  input  wire logic overheat_detect,
  output logic      winding_one_pos,
  output logic      winding_one_neg,
  output logic      winding_two_pos,
  output logic      winding_two_neg,
  output logic      fault_n,
  output logic      ready_for_step
);
  localparam int unsigned NSYNC = 8;

  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] sync_in;
  sps_ctrl_s        ctrl;
  logic             rst_n_s;
  logic             fault_in_s;
  logic             clk_prev_reg;
  logic             rst_n_prev_reg;
  logic             seq_rst;
  logic             rise;
  logic             fall;
  logic             step_ev;
  logic [2:0]       phase_reg;
  logic [2:0]       phase_next;
  logic             fault_reg;
  logic [$clog2(RESET_WAIT_CYC+1)-1:0] wait_reg;
  sps_drive_s       drive_tab;
  sps_drive_s       drive_reg;
  logic             drive_mute;
  logic             wait_done;

  // Every pin enters the clock domain through the agreement filter
  assign raw_in = {overheat_detect, overcurrent_detect, system_reset_n, excitation_select,
                   edge_select, direction_select, enable, step_clock};

  sps_sync #(.WIDTH(NSYNC)) u_sync (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .async_in(raw_in),
    .init_val('0),
    .sync_out(sync_in)
  );

  // Either detection feeds the fault latch
  assign fault_in_s = sync_in[7] | sync_in[6];
  assign rst_n_s    = sync_in[5];
  assign ctrl       = {sync_in[4], sync_in[3], sync_in[2], sync_in[1], sync_in[0]};

  // System reset or filtered pin reset
  // pin reset holds sequencer
  assign seq_rst = sys_rst | ~rst_n_s;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      clk_prev_reg   <= 1'b0;
      rst_n_prev_reg <= 1'b0;
    end else begin
      clk_prev_reg   <= ctrl.step_clock;
      rst_n_prev_reg <= rst_n_s;
    end
  end

  // Edge detect on the filtered step clock
  assign rise = ctrl.step_clock & ~clk_prev_reg;
  assign fall = ~ctrl.step_clock & clk_prev_reg;

  // First cycle out of reset is ignored: the filter leaves its cleared value
  // then, and a step clock held high would look like a rise
  // rising edges count
  assign step_ev = rst_n_prev_reg & (rise | (fall & ~ctrl.edge_select));

  always_comb begin
    phase_next = phase_reg;
    if (ctrl.excitation_select) begin
      phase_next = ctrl.direction_select ? phase_reg - 3'h1 : phase_reg + 3'h1;
    end else begin
      // Full-step lives on even indices; snap from a one-on state first
      if (phase_reg[0]) begin
        phase_next = ctrl.direction_select ? phase_reg - 3'h1 : phase_reg + 3'h1;
      end else begin
        phase_next = ctrl.direction_select ? phase_reg - 3'h2 : phase_reg + 3'h2;
      end
    end
  end

  // Steps still count while enable is low; a latched fault freezes the position
  // initial phase after reset
  always_ff @(posedge clk_sys) begin
    if (seq_rst) begin
      phase_reg <= PHASE_INIT;
    end else if (step_ev && !fault_reg) begin
      phase_reg <= phase_next;
    end
  end

  // Reset wins over a detection in the same cycle; a detection that is
  // still present sets the latch again once reset is released
  // fault flag
  always_ff @(posedge clk_sys) begin
    if (seq_rst) begin
      fault_reg <= 1'b0;
    end else if (fault_in_s) begin
      fault_reg <= 1'b1;
    end
  end

  // Reports when the post-reset wait has elapsed
  always_ff @(posedge clk_sys) begin
    if (seq_rst) begin
      wait_reg <= '0;
    end else if (!wait_done) begin
      wait_reg <= wait_reg + 1'b1;
    end
  end

  assign wait_done = (wait_reg == RESET_WAIT_CYC[$bits(wait_reg)-1:0]);

  // Wheel: 0 A+B-, 1 A, 2 A+B, 3 B, 4 An+B, 5 An, 6 An+Bn, 7 Bn
  always_comb begin
    drive_tab = DRIVE_OFF;
    case (phase_reg)
      3'h0: begin
        drive_tab.one_pos = 1'b1;
        drive_tab.two_neg = 1'b1;
      end
      3'h1: drive_tab.one_pos = 1'b1;
      3'h2: begin
        drive_tab.one_pos = 1'b1;
        drive_tab.two_pos = 1'b1;
      end
      3'h3: drive_tab.two_pos = 1'b1;
      3'h4: begin
        drive_tab.one_neg = 1'b1;
        drive_tab.two_pos = 1'b1;
      end
      3'h5: drive_tab.one_neg = 1'b1;
      3'h6: begin
        drive_tab.one_neg = 1'b1;
        drive_tab.two_neg = 1'b1;
      end
      default: drive_tab.two_neg = 1'b1;
    endcase
  end

  assign drive_mute = sys_rst | ~ctrl.enable | fault_reg | ~rst_n_s;

  // One drive flop per winding output
  genvar wi;
  generate
    for (wi = 0; wi < $bits(sps_drive_s); wi++) begin : g_drive
      always_ff @(posedge clk_sys) begin
        if (drive_mute) begin
          drive_reg[wi] <= 1'b0;
        end else begin
          drive_reg[wi] <= drive_tab[wi];
        end
      end
    end
  endgenerate

  assign winding_one_pos = drive_reg.one_pos;
  assign winding_one_neg = drive_reg.one_neg;
  assign winding_two_pos = drive_reg.two_pos;
  assign winding_two_neg = drive_reg.two_neg;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      fault_n <= 1'b1;
    end else begin
      fault_n <= ~fault_reg;
    end
  end

  // Ready once the pin reset is released and the wait has run out
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ready_for_step <= 1'b0;
    end else begin
      ready_for_step <= rst_n_prev_reg && wait_done;
    end
  end
endmodule
`default_nettype wire

// [testbench/sps_ctrl_model.sv]
// Step controller model: drives the step clock pin
`default_nettype none
module sps_ctrl_model (
  input  wire logic clk_sys,
  output var  logic step_clock
);
  timeunit 1ns;
  timeprecision 1ns;
  initial step_clock = 1'h0;
  task automatic pulse();
    repeat (100) @(negedge clk_sys);
    step_clock = 1'h1;
    repeat (100) @(negedge clk_sys);
    step_clock = 1'h0;
    repeat (100) @(negedge clk_sys);
  endtask
endmodule
`default_nettype wire

// [testbench/sps_sequencer_chk.sv]
// Checker: winding, fault and ready relations at the ports
`default_nettype none
module sps_sequencer_chk
  import sps_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic step_clock,
  input wire logic enable,
  input wire logic system_reset_n,
  input wire logic overcurrent_detect,
  input wire logic overheat_detect,
  input wire logic winding_one_pos,
  input wire logic winding_one_neg,
  input wire logic winding_two_pos,
  input wire logic winding_two_neg,
  input wire logic fault_n,
  input wire logic ready_for_step
);
  timeunit 1ns;
  timeprecision 1ns;
  sps_drive_s w;
  wire logic  hot = overcurrent_detect || overheat_detect;
  assign w = {winding_one_pos, winding_two_pos, winding_one_neg, winding_two_neg};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  fault_off_a: assert property (!fault_n [*2] |-> w == 4'h0)
    else $error("windings on in fault");
  disable_off_a: assert property (!enable [*6] |-> w == 4'h0)
    else $error("windings on while disabled");
  fault_sets_a: assert property ((hot && system_reset_n) [*7] |-> !fault_n)
    else $error("fault not flagged");
  fault_holds_a: assert property (system_reset_n [*6] ##0 !fault_n |=> !fault_n)
    else $error("fault cleared without reset");
  pin_reset_a: assert property (!system_reset_n [*7] |-> fault_n && w == 4'h0)
    else $error("reset pin not obeyed");
  no_step_hold_a: assert property (($stable(step_clock) && $stable(enable) && !hot
    && $stable(system_reset_n) && ready_for_step) [*8] |-> $stable(w))
    else $error("windings moved without step");
  start_state_a: assert property ($rose(ready_for_step) && enable |-> w == 4'h9)
    else $error("wrong start state");
  ready_wait_a: assert property (!system_reset_n [*7] |-> !ready_for_step)
    else $error("ready during reset");
  cover property ($fell(fault_n));
  cover property ($rose(ready_for_step));
  cover property ($fell(enable));
endmodule
bind sps_sequencer sps_sequencer_chk i_sps_sequencer_chk (
  .clk_sys           (clk_sys),
  .sys_rst           (sys_rst),
  .step_clock        (step_clock),
  .enable            (enable),
  .system_reset_n    (system_reset_n),
  .overcurrent_detect(overcurrent_detect),
  .overheat_detect   (overheat_detect),
  .winding_one_pos   (winding_one_pos),
  .winding_one_neg   (winding_one_neg),
  .winding_two_pos   (winding_two_pos),
  .winding_two_neg   (winding_two_neg),
  .fault_n           (fault_n),
  .ready_for_step    (ready_for_step)
);
`default_nettype wire

// [testbench/sps_sequencer_tb_top.sv]
// Testbench: step table, then enable, fault and reset cases
`default_nettype none
module sps_sequencer_tb_top
  import sps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'h0, sys_rst = 1'h1, enable = 1'h1, system_reset_n = 1'h1, step_clock;
  logic excitation_select = 1'h0, edge_select = 1'h1, direction_select = 1'h0;
  logic overcurrent_detect = 1'h0, overheat_detect = 1'h0, fault_n, ready_for_step;
  logic winding_one_pos, winding_one_neg, winding_two_pos, winding_two_neg;
  sps_drive_s w;
  int n_mismatch = 0, checked = 0;
  // Mode bits {half, rising only, reverse} and drive after one pulse
  logic [6:0] rows [13] = '{7'h68, 7'h6C, 7'h26, 7'h3C, 7'h03, 7'h56, 7'h74,
    7'h26, 7'h3C, 7'h39, 7'h33, 7'h61, 7'h69};
  assign w = {winding_one_pos, winding_two_pos, winding_one_neg, winding_two_neg};
  always #50 clk_sys = ~clk_sys;
  sps_sequencer  i_sps_sequencer (
    .clk_sys           (clk_sys),
    .sys_rst           (sys_rst),
    .step_clock        (step_clock),
    .excitation_select (excitation_select),
    .edge_select       (edge_select),
    .direction_select  (direction_select),
    .system_reset_n    (system_reset_n),
    .enable            (enable),
    .overcurrent_detect(overcurrent_detect),
    .overheat_detect   (overheat_detect),
    .winding_one_pos   (winding_one_pos),
    .winding_one_neg   (winding_one_neg),
    .winding_two_pos   (winding_two_pos),
    .winding_two_neg   (winding_two_neg),
    .fault_n           (fault_n),
    .ready_for_step    (ready_for_step)
  );
  sps_ctrl_model i_sps_ctrl_model (
    .clk_sys   (clk_sys),
    .step_clock(step_clock)
  );
  task automatic cmp(input string nm, input logic [3:0] e, input logic [3:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic cmp_flag(input string nm, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("FAIL %s exp %b got %b", nm, e, g);
    end
  endtask
  task automatic close_out();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  initial begin
    cyc(5);
    sys_rst = 1'h0;
    cyc(110);
    cmp("start", 4'h9, w);
    cmp_flag("start ready", 1'b1, ready_for_step);
    foreach (rows[k]) begin
      {excitation_select, edge_select, direction_select} = rows[k][6:4];
      i_sps_ctrl_model.pulse();
      cmp("step", rows[k][3:0], w);
    end
    enable = 1'h0;
    cyc(10);
    cmp("off", 4'h0, w);
    i_sps_ctrl_model.pulse();
    enable = 1'h1;
    cyc(10);
    cmp("resume", 4'h8, w);
    for (int d = 1; d < 3; d++) begin
      {overcurrent_detect, overheat_detect} = 2'(d);
      cyc(10);
      {overcurrent_detect, overheat_detect} = 2'h0;
      i_sps_ctrl_model.pulse();
      cmp_flag("fault", 1'b0, fault_n);
      cmp("latched", 4'h0, w);
      system_reset_n = 1'h0;
      cyc(10);
      cmp("held", 4'h0, w);
      cmp_flag("held ready", 1'b0, ready_for_step);
      system_reset_n = 1'h1;
      cyc(10);
      cmp_flag("waiting", 1'b0, ready_for_step);
      cyc(100);
      cmp_flag("cleared", 1'b1, fault_n);
      cmp("restart", 4'h9, w);
      cmp_flag("ready", 1'b1, ready_for_step);
    end
    // Second system reset in mid-run, taken from a moved position
    i_sps_ctrl_model.pulse();
    cmp("moved", 4'h8, w);
    sys_rst = 1'h1;
    cyc(5);
    cmp("in reset", 4'h0, w);
    cmp_flag("reset ready", 1'b0, ready_for_step);
    sys_rst = 1'h0;
    cyc(110);
    cmp("after reset", 4'h9, w);
    close_out();
  end
  // About twenty pulses of 30 us each; five times that
  initial begin
    #3_000_000;
    n_mismatch++;
    close_out();
  end
endmodule
`default_nettype wire
